// *** rtl/rts_pkg.sv ***
package rts_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] PWR_CTRL_ADDR    = 8'h8e;
  localparam logic [7:0] CAUSE_ADDR       = 8'h03;
  localparam int         SBE_BIT          = 4;
  localparam int         POR_BIT          = 1;
  localparam int         BOR_BIT          = 0;
  localparam int         TO_BIT           = 4;
  localparam int         PD_BIT           = 3;
  localparam logic       POR_FLAG_RST     = 1'b0;
  localparam logic       BOR_FLAG_RST     = 1'b1;
  localparam logic       SBE_RST          = 1'b0;
  localparam logic       TO_RST           = 1'b1;
  localparam logic       PD_RST           = 1'b1;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int SYS_CLK_NS   = 50;
  localparam int POWER_UP_DELAY_TIMER_MS      = 64;
  localparam int LF_OSC_KHZ   = 31;
  localparam int POWER_UP_DELAY_TIMER_TICKS   = POWER_UP_DELAY_TIMER_MS * LF_OSC_KHZ;
  localparam int OST_PERIODS  = 1024;
  localparam int BOR_MIN_NS   = 100000;
  localparam int BOR_MIN_CYC  = (BOR_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ***************************************************************
  // Modes and states
  // ***************************************************************
  typedef enum logic [1:0] {
    BOR_OFF      = 2'b00,
    BOR_SOFT     = 2'b01,
    BOR_NO_SLEEP = 2'b10,
    BOR_ON       = 2'b11
  } rts_bor_mode_t;

  typedef enum logic [2:0] {
    OSC_LP    = 3'b000,
    OSC_XT    = 3'b001,
    OSC_HS    = 3'b010,
    OSC_EC    = 3'b011,
    OSC_INTIO = 3'b100,
    OSC_INT   = 3'b101,
    OSC_RCIO  = 3'b110,
    OSC_RC    = 3'b111
  } rts_osc_mode_t;

  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_POWER_UP_DELAY_TIMER = 2'b01,
    SEQ_OST  = 2'b10,
    SEQ_RUN  = 2'b11
  } rts_seq_t;

  typedef struct packed {
    rts_bor_mode_t brownout_mode_select;
    logic          power_up_delay_enable_n;
    rts_osc_mode_t osc_mode;
    logic          two_speed_en;
    logic          fail_safe_en;
  } rts_cfg_t;

endpackage

// *** rtl/rts_top.sv ***
`timescale 1ns/10ps
module rts_top #(
  parameter int POWER_UP_DELAY_TIMER_TICKS  = rts_pkg::POWER_UP_DELAY_TIMER_TICKS,
  parameter int OST_PERIODS = rts_pkg::OST_PERIODS,
  parameter int BOR_MIN_CYC = rts_pkg::BOR_MIN_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire rts_pkg::rts_cfg_t cfg,
  input  wire logic             por_active,
  input  wire logic             supply_below_bor,
  input  wire logic             low_freq_internal_osc,
  input  wire logic             osc_period_tick,
  input  wire logic             external_reset_n,
  input  wire logic             sleep_cmd,
  input  wire logic             wdt_clear,
  input  wire logic             wdt_timeout,
  input  wire logic             wake_irq,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic [7:0]            rd_data,
  output logic                  chip_reset,
  output logic                  core_stall,
  output logic                  run_on_internal_osc,
  output logic                  brownout_enabled,
  output logic                  in_sleep
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam int OW = $clog2(OST_PERIODS + 1);
  localparam int BW = $clog2(BOR_MIN_CYC + 1);

  rts_pkg::rts_seq_t state_q, state_d;
  logic [PW-1:0]  power_up_delay_timer_cnt_q;
  logic [OW-1:0]  ost_cnt_q;
  logic [BW-1:0]  low_cnt_q;
  logic           bor_rst_q;
  logic           lf_q;
  logic           sleep_q;
  logic           wake_ost_q;
  logic           soft_bor_en_q;
  logic           por_flag_n_q;
  logic           bor_flag_n_q;
  logic           to_flag_n_q;
  logic           pd_flag_n_q;
  logic [7:0]     rd_data_q;

  // ***************************************************************
  // Decode and status
  // ***************************************************************
  // Crystal modes need the start-up count; the rest do not
  wire crystal   = (cfg.osc_mode == rts_pkg::OSC_LP) ||
                   (cfg.osc_mode == rts_pkg::OSC_XT) ||
                   (cfg.osc_mode == rts_pkg::OSC_HS);
  wire power_up_delay_timer_en   = ~cfg.power_up_delay_enable_n;
  wire fast_boot = cfg.two_speed_en | cfg.fail_safe_en;
  wire lf_tick   = low_freq_internal_osc & ~lf_q;
  wire pwr_src   = por_active | bor_rst_q;
  wire power_up_delay_timer_done = (power_up_delay_timer_cnt_q == PW'(POWER_UP_DELAY_TIMER_TICKS - 1)) & lf_tick;
  wire ost_done  = (ost_cnt_q == OW'(OST_PERIODS - 1)) &
                   osc_period_tick;
  wire wdt_rst   = wdt_timeout & ~sleep_q;
  wire wdt_wake  = wdt_timeout & sleep_q;
  wire ext_sleep = ~external_reset_n & sleep_q;
  wire wake_ev   = (wake_irq | wdt_wake) & sleep_q;
  wire sel_pwr   = wr_en & (addr == rts_pkg::PWR_CTRL_ADDR);
  wire rd_pwr    = rd_en & (addr == rts_pkg::PWR_CTRL_ADDR);
  wire rd_cause  = rd_en & (addr == rts_pkg::CAUSE_ADDR);

  // Sleep-gated mode ignores the soft bit; mode 00 is always off
  assign brownout_enabled =
    (cfg.brownout_mode_select == rts_pkg::BOR_ON) |
    ((cfg.brownout_mode_select == rts_pkg::BOR_NO_SLEEP) & ~sleep_q) |
    ((cfg.brownout_mode_select == rts_pkg::BOR_SOFT) &
     soft_bor_en_q);

  // Execution released during start-up only when the internal clock
  // can carry the core; otherwise held in reset or stalled
  assign run_on_internal_osc = (state_q == rts_pkg::SEQ_OST) & fast_boot;
  assign chip_reset = (state_q == rts_pkg::SEQ_HOLD) |
                      (state_q == rts_pkg::SEQ_POWER_UP_DELAY_TIMER) |
                      ((state_q == rts_pkg::SEQ_OST) & ~wake_ost_q &
                       ~fast_boot) |
                      ~external_reset_n | wdt_rst;
  assign core_stall = (state_q == rts_pkg::SEQ_OST) & wake_ost_q &
                      ~fast_boot;
  assign in_sleep   = sleep_q;
  assign rd_data    = rd_data_q;

  // ***************************************************************
  // Brown-out qualification
  // ***************************************************************
  // Dips shorter than the minimum are filtered; a long dip latches
  // reset until the supply is back above threshold
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_cnt_q <= '0;
      bor_rst_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= (supply_below_bor & brownout_enabled &
                    low_cnt_q != BW'(BOR_MIN_CYC)) ?
                   low_cnt_q + BW'(1) :
                   (supply_below_bor ? low_cnt_q : '0);
      bor_rst_q <= supply_below_bor &
                   (bor_rst_q | low_cnt_q == BW'(BOR_MIN_CYC));
    end
  end

  // ***************************************************************
  // Time-out sequencer
  // ***************************************************************
  // Next state; any power source restarts the whole chain
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      rts_pkg::SEQ_HOLD:
        state_d = power_up_delay_timer_en ? rts_pkg::SEQ_POWER_UP_DELAY_TIMER :
                  (crystal ? rts_pkg::SEQ_OST : rts_pkg::SEQ_RUN);
      rts_pkg::SEQ_POWER_UP_DELAY_TIMER:
        if (power_up_delay_timer_done)
          state_d = crystal ? rts_pkg::SEQ_OST : rts_pkg::SEQ_RUN;
      rts_pkg::SEQ_OST:
        if (ost_done)
          state_d = rts_pkg::SEQ_RUN;
      rts_pkg::SEQ_RUN:
        if (wake_ev & crystal)
          state_d = rts_pkg::SEQ_OST;
    endcase
    if (pwr_src)
      state_d = rts_pkg::SEQ_HOLD;
  end

  // State and counters; counters clear whenever not in their phase
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= rts_pkg::SEQ_HOLD;
      power_up_delay_timer_cnt_q <= '0;
      ost_cnt_q  <= '0;
      lf_q       <= 1'b0;
      wake_ost_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      lf_q       <= low_freq_internal_osc;
      power_up_delay_timer_cnt_q <= (state_q == rts_pkg::SEQ_POWER_UP_DELAY_TIMER && !pwr_src) ?
                    power_up_delay_timer_cnt_q + PW'(lf_tick) : '0;
      ost_cnt_q  <= (state_q == rts_pkg::SEQ_OST && !pwr_src) ?
                    ost_cnt_q + OW'(osc_period_tick) : '0;
      wake_ost_q <= pwr_src ? 1'b0 : (wake_ev | wake_ost_q) &
                    (state_d == rts_pkg::SEQ_OST);
    end
  end

  // ***************************************************************
  // Sleep tracking
  // ***************************************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= ~(pwr_src | wake_ev | ext_sleep) & (sleep_cmd | sleep_q);
  end

  // ***************************************************************
  // Power-control and cause flags
  // ***************************************************************
  // Hardware clears take priority over a software write of one, so an
  // event landing on the write cycle is never lost
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      soft_bor_en_q <= rts_pkg::SBE_RST;
      por_flag_n_q  <= rts_pkg::POR_FLAG_RST;
      bor_flag_n_q  <= rts_pkg::BOR_FLAG_RST;
    end
    else
    begin
      if (sel_pwr)
        soft_bor_en_q <= wr_data[rts_pkg::SBE_BIT];
      if (por_active)
        por_flag_n_q <= 1'b0;
      else if (sel_pwr)
        por_flag_n_q <= wr_data[rts_pkg::POR_BIT];
      if (bor_rst_q)
        bor_flag_n_q <= 1'b0;
      else if (sel_pwr)
        bor_flag_n_q <= wr_data[rts_pkg::BOR_BIT];
    end
  end

  // Timeout and powerdown flags, priority by event class
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      to_flag_n_q <= rts_pkg::TO_RST;
      pd_flag_n_q <= rts_pkg::PD_RST;
    end
    else if (pwr_src)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b1;
    end
    else if (wdt_wake)
    begin
      to_flag_n_q <= 1'b0;
      pd_flag_n_q <= 1'b0;
    end
    else if (wdt_rst)
      to_flag_n_q <= 1'b0;
    else if (ext_sleep | sleep_cmd)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b0;
    end
    else if (wdt_clear)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b1;
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  // Read words; unimplemented bits read as zero
  logic [7:0] pwr_word;
  logic [7:0] cause_word;

  always_comb
  begin
    pwr_word                    = 8'h00;
    pwr_word[rts_pkg::SBE_BIT]  = soft_bor_en_q;
    pwr_word[rts_pkg::POR_BIT]  = por_flag_n_q;
    pwr_word[rts_pkg::BOR_BIT]  = bor_flag_n_q;
    cause_word                  = 8'h00;
    cause_word[rts_pkg::TO_BIT] = to_flag_n_q;
    cause_word[rts_pkg::PD_BIT] = pd_flag_n_q;
  end

  // Data valid only in the cycle after the strobe, zero otherwise

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= rd_pwr ? pwr_word : (rd_cause ? cause_word : 8'h00);
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_power_up_delay_timer_holds_reset: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_q == rts_pkg::SEQ_POWER_UP_DELAY_TIMER |-> chip_reset)
    else $error("reset released during power-up delay");

  a_bypass_no_power_up_delay_timer: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (cfg.power_up_delay_enable_n && state_q == rts_pkg::SEQ_HOLD) |=>
    state_q != rts_pkg::SEQ_POWER_UP_DELAY_TIMER)
    else $error("delay entered while bypassed");

  a_ec_no_timeout: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_q == rts_pkg::SEQ_HOLD && !pwr_src && !crystal &&
     cfg.power_up_delay_enable_n) |=> state_q == rts_pkg::SEQ_RUN)
    else $error("no-timeout mode did not release");

  a_src_restarts: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    pwr_src |=> state_q == rts_pkg::SEQ_HOLD && power_up_delay_timer_cnt_q == '0)
    else $error("power source did not restart sequence");

  a_power_up_delay_timer_to_ost: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_q == rts_pkg::SEQ_POWER_UP_DELAY_TIMER && power_up_delay_timer_done && !pwr_src && crystal)
    |=> state_q == rts_pkg::SEQ_OST ##0 ost_cnt_q == '0)
    else $error("start-up count did not follow delay");

  a_bor_clears_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    bor_rst_q |=> !bor_flag_n_q)
    else $error("brown-out flag not cleared");

  a_por_clears_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    por_active |=> !por_flag_n_q ##1
    (por_active || !por_flag_n_q || $past(sel_pwr)))
    else $error("power-on flag not cleared");

  a_mode_off: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    cfg.brownout_mode_select == rts_pkg::BOR_OFF |-> !brownout_enabled)
    else $error("detection on in mode 00");

  a_wdt_wake_flags: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wdt_wake && !pwr_src) |=> !to_flag_n_q && !pd_flag_n_q && !sleep_q)
    else $error("watchdog wake flags wrong");

  a_short_dip: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(supply_below_bor) && !bor_rst_q |=> !bor_rst_q)
    else $error("single-cycle dip caused reset");

  c_full_boot: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_q == rts_pkg::SEQ_OST ##1 state_q == rts_pkg::SEQ_RUN);
  c_bor_in_power_up_delay_timer: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_q == rts_pkg::SEQ_POWER_UP_DELAY_TIMER && bor_rst_q);
  c_wake_ost: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
    core_stall);

endmodule

// *** sim/rts_supply_model.sv ***
`timescale 1ns/10ps
// ***************************************************************
// Supply detectors, reset pin and oscillators
// ***************************************************************
module rts_supply_model #(
  parameter int LF_HALF = 5
) (
  input  wire logic sys_clk,
  input  wire logic por_req,
  input  wire logic dip_req,
  input  wire logic ext_hold,
  output logic      por_active,
  output logic      supply_below_bor,
  output logic      external_reset_n,
  output logic      low_freq_internal_osc,
  output logic      osc_period_tick
);
  int   lf_cnt = 0;
  logic lf_q   = 1'b0;
  logic tick_q = 1'b0;

  // Detector levels follow the bench's requests directly
  assign por_active            = por_req;
  assign supply_below_bor      = dip_req;
  assign external_reset_n      = ~ext_hold;
  assign low_freq_internal_osc = lf_q;
  assign osc_period_tick       = tick_q;

  // Slow oscillator free-runs, scaled down so delays stay short
  always @(posedge sys_clk)
  begin
    lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
    if (lf_cnt == LF_HALF - 1)
      lf_q <= ~lf_q;
    tick_q <= ~tick_q;  // One period per two clocks
  end
endmodule

// *** sim/rts_top_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
  end
module rts_top_tb;
  localparam logic [7:0] PC = rts_pkg::PWR_CTRL_ADDR;
  localparam logic [7:0] CA = rts_pkg::CAUSE_ADDR;
  logic              sys_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              por_req = 1'b1;
  logic              dip_req = 1'b0;
  logic              ext_hold = 1'b0;
  logic              sleep_cmd = 1'b0;
  logic              wake_irq = 1'b0;
  logic              wdt_timeout = 1'b0;
  logic              wdt_clear = 1'b0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wr_data = 8'h00;
  logic [7:0]        rd_data, rv;
  logic              por_active, supply_below_bor, external_reset_n;
  logic              low_freq_internal_osc, osc_period_tick;
  logic              chip_reset, core_stall, run_on_internal_osc;
  logic              brownout_enabled, in_sleep;
  rts_pkg::rts_cfg_t cfg = '0;
  int                fails = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                n;

  always #25 sys_clk = ~sys_clk;

  rts_top #(.POWER_UP_DELAY_TIMER_TICKS(4), .OST_PERIODS(4), .BOR_MIN_CYC(3)) u_rts_top (
    .sys_clk(sys_clk), .arst_n(arst_n), .cfg(cfg),
    .por_active(por_active), .supply_below_bor(supply_below_bor),
    .low_freq_internal_osc(low_freq_internal_osc),
    .osc_period_tick(osc_period_tick),
    .external_reset_n(external_reset_n), .sleep_cmd(sleep_cmd),
    .wdt_clear(wdt_clear), .wdt_timeout(wdt_timeout),
    .wake_irq(wake_irq), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .chip_reset(chip_reset), .core_stall(core_stall),
    .run_on_internal_osc(run_on_internal_osc),
    .brownout_enabled(brownout_enabled), .in_sleep(in_sleep));

  rts_supply_model #(.LF_HALF(5)) u_rts_supply_model (
    .sys_clk(sys_clk), .por_req(por_req), .dip_req(dip_req),
    .ext_hold(ext_hold), .por_active(por_active),
    .supply_below_bor(supply_below_bor),
    .external_reset_n(external_reset_n),
    .low_freq_internal_osc(low_freq_internal_osc),
    .osc_period_tick(osc_period_tick));

  // ***************************************************************
  // Bus, event and sequencing helpers
  // ***************************************************************
  task automatic close_out;
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard: whole run needs under a thousand cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out;
    end
  end

  function automatic logic in_rng(int v, int lo, int hi);
    return (v >= lo && v <= hi);
  endfunction

  function automatic rts_pkg::rts_cfg_t mk(rts_pkg::rts_bor_mode_t m,
    logic pe, rts_pkg::rts_osc_mode_t o, logic ts);
    return {m, pe, o, ts, 1'b0};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // Read data is valid only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
    input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
    `CHK(nm, e, rv)
  endtask

  // 0 sleep, 1 wake, 2 watchdog expiry, 3 watchdog clear, 4 pin reset
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: sleep_cmd <= 1'b1;
      1: wake_irq <= 1'b1;
      2: wdt_timeout <= 1'b1;
      3: wdt_clear <= 1'b1;
      default: ext_hold <= 1'b1;
    endcase
    @(posedge sys_clk);
    {sleep_cmd, wake_irq, wdt_timeout, wdt_clear, ext_hold} <= 5'h00;
    #1;
  endtask

  // Count cycles until internal reset drops, capped at 300
  task automatic wait_rel(output int c);
    #1;
    c = 0;
    while (chip_reset !== 1'b0 && c < 300)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask

  task automatic por_seq(input rts_pkg::rts_cfg_t c, output int c_out);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    por_req <= 1'b1;
    cfg <= c;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    por_req <= 1'b0;
    wait_rel(c_out);
  endtask

  // Dip held well past the minimum duration
  task automatic dip;
    @(posedge sys_clk);
    dip_req <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial
  begin
    por_seq(mk(rts_pkg::BOR_ON, 1'b0, rts_pkg::OSC_EC, 1'b0), n);
    `CHK("power_up_delay_timer_len", 1'b1, in_rng(n, 30, 46));
    rdchk(PC, 8'h01, "power_control_status_por");
    rdchk(CA, 8'h18, "cause_por");
    wr(PC, 8'h13);
    rdchk(PC, 8'h13, "power_control_status_set");
    wr(CA, 8'h00);
    rdchk(CA, 8'h18, "cause_ro");
    wr(8'h55, 8'hff);
    rdchk(8'h55, 8'h00, "unmapped");
    dip();
    `CHK("bor_hold", 1'b1, chip_reset);
    @(posedge sys_clk) dip_req <= 1'b0;
    wait_rel(n);
    `CHK("bor_delay", 1'b1, in_rng(n, 30, 46));
    rdchk(PC, 8'h12, "power_control_status_bor");
    rdchk(CA, 8'h18, "cause_bor");
    // Second dip part way through the delay
    dip();
    @(posedge sys_clk) dip_req <= 1'b0;
    repeat (15) @(posedge sys_clk);
    #1;
    `CHK("mid_hold", 1'b1, chip_reset);
    dip();
    @(posedge sys_clk) dip_req <= 1'b0;
    wait_rel(n);
    `CHK("restart", 1'b1, in_rng(n, 30, 46));
    // Crystal: delay then start-up count, also on wake
    por_seq(mk(rts_pkg::BOR_OFF, 1'b0, rts_pkg::OSC_XT, 1'b0), n);
    `CHK("xt_len", 1'b1, in_rng(n, 37, 58));
    `CHK("bor_off", 1'b0, brownout_enabled);
    pulse(0);
    pulse(1);
    `CHK("wake_stall", 1'b1, core_stall);
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK("stall_end", 1'b0, core_stall);
    por_seq(mk(rts_pkg::BOR_OFF, 1'b1, rts_pkg::OSC_XT, 1'b0), n);
    `CHK("ost_only", 1'b1, in_rng(n, 6, 14));
    por_seq(mk(rts_pkg::BOR_OFF, 1'b1, rts_pkg::OSC_XT, 1'b1), n);
    `CHK("fast_boot", 1'b1, run_on_internal_osc);
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK("fast_end", 1'b0, run_on_internal_osc);
    // High-speed crystal with the fail-safe monitor
    por_seq('{rts_pkg::BOR_OFF, 1'b1, rts_pkg::OSC_HS, 1'b0, 1'b1}, n);
    `CHK("fsm_boot", 1'b1, run_on_internal_osc);
    `CHK("fsm_rel", 1'b1, (n == 1));
    // Resistor-capacitor mode: power-up delay only
    por_seq(mk(rts_pkg::BOR_OFF, 1'b0, rts_pkg::OSC_RC, 1'b0), n);
    `CHK("rc_len", 1'b1, in_rng(n, 30, 46));
    // Software-switched detector
    por_seq(mk(rts_pkg::BOR_SOFT, 1'b0, rts_pkg::OSC_EC, 1'b0), n);
    `CHK("soft_off", 1'b0, brownout_enabled);
    wr(PC, 8'h10);
    `CHK("soft_on", 1'b1, brownout_enabled);
    wr(PC, 8'h00);
    `CHK("soft_off2", 1'b0, brownout_enabled);
    // Pin held low past the time-outs releases at once
    @(posedge sys_clk) ext_hold <= 1'b1;
    por_seq(mk(rts_pkg::BOR_OFF, 1'b0, rts_pkg::OSC_XT, 1'b0), n);
    `CHK("pin_hold", 1'b1, (n == 300));
    @(posedge sys_clk) ext_hold <= 1'b0;
    #1;
    `CHK("pin_rel", 1'b0, chip_reset);
    // Sleep-gated detector and cause flags
    por_seq(mk(rts_pkg::BOR_NO_SLEEP, 1'b1, rts_pkg::OSC_EC, 1'b0), n);
    `CHK("no_delay", 1'b1, in_rng(n, 0, 2));
    `CHK("ns_awake", 1'b1, brownout_enabled);
    pulse(0);
    `CHK("asleep", 1'b1, in_sleep);
    `CHK("ns_sleep", 1'b0, brownout_enabled);
    rdchk(CA, 8'h10, "cause_slp");
    pulse(1);
    `CHK("ns_wake", 1'b1, brownout_enabled);
    pulse(0);
    pulse(2);
    rdchk(CA, 8'h00, "wdt_wake");
    pulse(3);
    rdchk(CA, 8'h18, "wdt_clr");
    pulse(2);
    rdchk(CA, 8'h08, "wdt_rst");
    pulse(4);
    rdchk(CA, 8'h08, "pin_run");
    pulse(0);
    pulse(4);
    rdchk(CA, 8'h10, "pin_slp");
    `CHK("pin_wake", 1'b0, in_sleep);
    close_out;
  end
endmodule
